// *** logic/adsc_defines.vh ***
// register map, field positions, reset values and timing counts of the
// converter sequencing block; included by the design file by bare name
`ifndef ADSC_DEFINES_VH
`define ADSC_DEFINES_VH
// byte offsets on the register bus
`define ADSC_OFS_CTRL   8'h00
`define ADSC_OFS_POS    8'h04
`define ADSC_OFS_NEG    8'h08
`define ADSC_OFS_STAT   8'h0c
`define ADSC_OFS_RES    8'h10
`define ADSC_OFS_SRST   8'h14
`define ADSC_OFS_GAIN   8'h18
`define ADSC_OFS_OFFS   8'h1c
`define ADSC_OFS_AMP    8'h20
`define ADSC_OFS_PORT   8'h24
// reset values
`define ADSC_CTRL_RST   16'h0a00
`define ADSC_GAIN_RST   12'h800
`define ADSC_OFFS_RST   12'h000
// control field positions
`define ADSC_BYP_P      15
`define ADSC_BYP_N      14
`define ADSC_DIV_HI     13
`define ADSC_DIV_LO     11
`define ADSC_ACQ_HI     10
`define ADSC_ACQ_LO     8
`define ADSC_ENA        7
`define ADSC_PWR        5
`define ADSC_MODE_HI    4
`define ADSC_MODE_LO    3
// conversion modes and trigger types
`define ADSC_MODE_DIFF  2'h1
`define ADSC_TRG_PIN    3'h0
`define ADSC_TRG_TMR1   3'h1
`define ADSC_TRG_TMR0   3'h2
`define ADSC_TRG_SINGLE 3'h3
`define ADSC_TRG_CONT   3'h4
`define ADSC_TRG_PLA    3'h5
`define ADSC_TRG_PWM    3'h6
// channel codes
`define ADSC_CH_TEMP    5'h0d
`define ADSC_CH_AMP_B   5'h01
// timing in converter clocks; the divider values are clk cycles per converter clock
`define ADSC_TRIAL_CLKS 5'd19
`define ADSC_TEMP_ACQ   7'd16
`define ADSC_TEMP_DIV   6'd32
`define ADSC_DIV_RST    6'h02
`define ADSC_ACQ_RST    7'h08
`endif

// *** logic/adsc_top.v ***
// converter sequencing and result handling behind an axi4-lite slave
// assumes one clock; raw code and triggers from timers come from logic on
// clk, the external convert pin is asynchronous and is synchronised here
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`include "adsc_defines.vh"

module adsc_top (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // axi4-lite write address and data
  input  wire [7:0]  s_awaddr,
  input  wire        s_awvalid,
  output wire        s_awready,
  input  wire [31:0] s_wdata,
  input  wire [3:0]  s_wstrb,
  input  wire        s_wvalid,
  output wire        s_wready,
  // axi4-lite write response
  output reg  [1:0]  s_bresp,
  output reg         s_bvalid,
  input  wire        s_bready,
  // axi4-lite read
  input  wire [7:0]  s_araddr,
  input  wire        s_arvalid,
  output wire        s_arready,
  output reg  [31:0] s_rdata,
  output reg  [1:0]  s_rresp,
  output reg         s_rvalid,
  input  wire        s_rready,
  // conversion triggers
  input  wire        convst_pin,
  input  wire        timer0_ovf,
  input  wire        timer1_ovf,
  input  wire        pla_trig,
  input  wire        pwm_trig,
  // analog core
  input  wire [11:0] raw_code,
  output reg         sample_hold,
  output reg         adc_power,
  output reg  [4:0]  pos_sel,
  output reg  [4:0]  neg_sel,
  output reg         pos_buf_bypass,
  output reg         neg_buf_bypass,
  output reg  [4:0]  amp_gain,
  // status pins
  output reg         adc_busy,
  output reg         port_busy_pin,
  output reg         adc_irq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_ACQ  = 2'd1;
  localparam ST_CONV = 2'd2;
  // registers
  reg [15:0] ctrl_r;
  reg [4:0]  pos_r;
  reg [4:0]  neg_r;
  reg [11:0] gain_r;
  reg [11:0] offs_r;
  reg [4:0]  amp_r;
  reg        port_r;
  reg        ready_r;
  reg [31:0] result_r;
  // sequencer
  reg [1:0]  state_r;
  reg [5:0]  div_cnt_r;
  reg [5:0]  div_lim_r;
  reg [6:0]  cnt_r;
  reg [6:0]  acq_lim_r;
  reg        diff_r;
  reg        amp_ch_r;
  // bus
  reg        aw_have_r;
  reg        w_have_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  // pin synchroniser and trigger edges
  reg        pin_s1_r;
  reg        pin_s2_r;
  reg        pin_s3_r;
  reg        pin_lvl_r;
  reg        t0_d_r;
  reg        t1_d_r;
  reg        pla_d_r;
  reg        pwm_d_r;
  wire [2:0] trg_type = ctrl_r[2:0];
  wire [2:0] div_code = ctrl_r[`ADSC_DIV_HI:`ADSC_DIV_LO];
  wire [2:0] acq_code = ctrl_r[`ADSC_ACQ_HI:`ADSC_ACQ_LO];
  wire [1:0] mode     = ctrl_r[`ADSC_MODE_HI:`ADSC_MODE_LO];
  wire       conv_ok  = ctrl_r[`ADSC_ENA] & ctrl_r[`ADSC_PWR];
  // bus handshakes; one write and one read in flight at most
  assign s_awready = ~aw_have_r & ~s_bvalid;
  assign s_wready  = ~w_have_r & ~s_bvalid;
  assign s_arready = ~s_rvalid;
  wire       aw_fire = s_awvalid & s_awready;
  wire       w_fire  = s_wvalid & s_wready;
  wire       ar_fire = s_arvalid & s_arready;
  wire       aw_now  = aw_have_r | aw_fire;
  wire       w_now   = w_have_r | w_fire;
  wire       wr_go   = aw_now & w_now & ~s_bvalid;
  wire [7:0] wa      = aw_have_r ? awaddr_r : s_awaddr;
  wire [31:0] wd     = w_have_r ? wdata_r : s_wdata;
  wire [3:0] ws      = w_have_r ? wstrb_r : s_wstrb;
  wire [31:0] wmask  = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  // soft reset: any write to its word restores every default except the bus channels and the trigger synchroniser
  wire soft_rst = wr_go & (wa == `ADSC_OFS_SRST);
  wire any_rst  = rst | soft_rst;
  wire [31:0] ctrl_ext = {16'h0000, ctrl_r};
  wire [31:0] ctrl_new = (ctrl_ext & ~wmask) | (wd & wmask);
  wire [31:0] pos_new  = ({27'h0, pos_r} & ~wmask) | (wd & wmask);
  wire [31:0] neg_new  = ({27'h0, neg_r} & ~wmask) | (wd & wmask);
  wire [31:0] gain_new = ({20'h0, gain_r} & ~wmask) | (wd & wmask);
  wire [31:0] offs_new = ({20'h0, offs_r} & ~wmask) | (wd & wmask);
  wire [31:0] amp_new  = ({27'h0, amp_r} & ~wmask) | (wd & wmask);
  function map_ok;
    input [7:0] a;
    begin
      map_ok = (a <= `ADSC_OFS_PORT) && (a[1:0] == 2'b00);
    end
  endfunction
  // trigger sources; the convert pin counts once stages two and three agree
  wire pin_rise = pin_lvl_r == 1'b0 && pin_s2_r && pin_s3_r;
  wire pin_fall = pin_lvl_r == 1'b1 && !pin_s2_r && !pin_s3_r;
  reg  trig;
  always @* begin
    trig = 1'b0;
    case (trg_type)
      `ADSC_TRG_PIN:    trig = pin_rise;
      `ADSC_TRG_TMR1:   trig = timer1_ovf & ~t1_d_r;
      `ADSC_TRG_TMR0:   trig = timer0_ovf & ~t0_d_r;
      `ADSC_TRG_SINGLE: trig = 1'b1;
      `ADSC_TRG_CONT:   trig = 1'b1;
      `ADSC_TRG_PLA:    trig = pla_trig & ~pla_d_r;
      `ADSC_TRG_PWM:    trig = pwm_trig & ~pwm_d_r;
      default:          trig = 1'b0;
    endcase
  end
  // per-conversion timing; the temperature channel overrides user codes
  wire        temp_ch = pos_r == `ADSC_CH_TEMP;
  wire [5:0]  user_div = 6'h01 << div_code;
  wire [6:0]  user_acq = 7'h02 << acq_code;
  wire [5:0]  next_div = temp_ch ? `ADSC_TEMP_DIV : user_div;
  wire [6:0]  next_acq = temp_ch ? `ADSC_TEMP_ACQ : user_acq;
  wire        tick     = div_cnt_r == div_lim_r - 6'h01;
  wire        start    = state_r == ST_IDLE && conv_ok && trig;
  wire        acq_end  = state_r == ST_ACQ && tick &&
                         cnt_r == acq_lim_r - 7'h01;
  wire        done     = state_r == ST_CONV && tick &&
                         cnt_r == {2'b00, `ADSC_TRIAL_CLKS} - 7'h01;
  // calibration: gain only off the amplified pairs, offset everywhere
  wire [23:0] gprod  = raw_code * gain_r;
  wire [12:0] gscl   = gprod[23:11];
  wire [11:0] gsat   = gscl[12] ? 12'hfff : gscl[11:0];
  wire [11:0] gsel   = amp_ch_r ? raw_code : gsat;
  wire [13:0] osum   = {2'b00, gsel} + {{2{offs_r[11]}}, offs_r};
  wire [11:0] cal    = osum[13] ? 12'h000 :
                       (osum[12] ? 12'hfff : osum[11:0]);
  // differential codes are offset binary from the core, flip to signed
  wire [11:0] fmt    = diff_r ? (cal ^ 12'h800) : cal;
  wire [3:0]  sgn    = (diff_r & fmt[11]) ? 4'hf : 4'h0;
  // sequencer: idle, acquisition, bit trials
  always @(posedge clk) begin
    if (any_rst) begin
      state_r   <= ST_IDLE;
      div_cnt_r <= 6'h00;
      div_lim_r <= `ADSC_DIV_RST;
      cnt_r     <= 7'h00;
      acq_lim_r <= `ADSC_ACQ_RST;
      diff_r    <= 1'b0;
      amp_ch_r  <= 1'b0;
    end else begin
      div_cnt_r <= (tick || state_r == ST_IDLE) ? 6'h00
                                                : div_cnt_r + 6'h01;
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r   <= ST_ACQ;
            div_lim_r <= next_div;
            acq_lim_r <= next_acq;
            cnt_r     <= 7'h00;
            diff_r    <= mode == `ADSC_MODE_DIFF;
            amp_ch_r  <= pos_r <= `ADSC_CH_AMP_B;
          end
        end
        ST_ACQ: begin
          if (acq_end) begin
            state_r <= ST_CONV;
            cnt_r   <= 7'h00;
          end else if (tick) begin
            cnt_r <= cnt_r + 7'h01;
          end
        end
        ST_CONV: begin
          // back to idle keeps the limits; the next start loads timing for its channel
          if (done) begin
            state_r <= ST_IDLE;
          end else if (tick) begin
            cnt_r <= cnt_r + 7'h01;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  // status outputs; busy and ready change on the same edge
  always @(posedge clk) begin
    if (any_rst) begin
      adc_busy      <= 1'b0;
      sample_hold   <= 1'b0;
      port_busy_pin <= 1'b0;
      adc_irq       <= 1'b0;
    end else begin
      if (start)
        adc_busy <= 1'b1;
      else if (done)
        adc_busy <= 1'b0;
      sample_hold   <= start | (state_r == ST_ACQ & ~acq_end);
      port_busy_pin <= port_r & (start | (adc_busy & ~done));
      adc_irq       <= done | (ready_r & ~(ar_fire &
                       s_araddr == `ADSC_OFS_RES));
    end
  end
  // configuration outputs to the analog core follow the registers
  always @(posedge clk) begin
    if (any_rst) begin
      adc_power      <= 1'b0;
      pos_sel        <= 5'h00;
      neg_sel        <= 5'h00;
      pos_buf_bypass <= 1'b0;
      neg_buf_bypass <= 1'b0;
      amp_gain       <= 5'h00;
    end else begin
      adc_power      <= ctrl_r[`ADSC_PWR];
      pos_sel        <= pos_r;
      neg_sel        <= neg_r;
      pos_buf_bypass <= ctrl_r[`ADSC_BYP_P];
      neg_buf_bypass <= ctrl_r[`ADSC_BYP_N];
      amp_gain       <= amp_r;
    end
  end
  // result and ready flag; a finishing conversion beats a clearing read
  always @(posedge clk) begin
    if (any_rst) begin
      ready_r  <= 1'b0;
      result_r <= 32'h0000_0000;
    end else begin
      if (done) begin
        ready_r  <= 1'b1;
        result_r <= {sgn, fmt, 16'h0000};
      end else if (ar_fire && s_araddr == `ADSC_OFS_RES) begin
        ready_r <= 1'b0;
      end
    end
  end
  // software registers; soft reset itself keeps no state
  always @(posedge clk) begin
    if (any_rst) begin
      ctrl_r <= `ADSC_CTRL_RST;
      pos_r  <= 5'h00;
      neg_r  <= 5'h00;
      gain_r <= `ADSC_GAIN_RST;
      offs_r <= `ADSC_OFFS_RST;
      amp_r  <= 5'h00;
      port_r <= 1'b0;
    end else begin
      if (wr_go) begin
        case (wa)
          `ADSC_OFS_CTRL: ctrl_r <= {ctrl_new[15:7], 1'b0, ctrl_new[5:0]};
          `ADSC_OFS_POS:  pos_r  <= pos_new[4:0];
          `ADSC_OFS_NEG:  neg_r  <= neg_new[4:0];
          `ADSC_OFS_GAIN: gain_r <= gain_new[11:0];
          `ADSC_OFS_OFFS: offs_r <= offs_new[11:0];
          `ADSC_OFS_AMP:  amp_r  <= amp_new[4:0];
          `ADSC_OFS_PORT: port_r <= ws[0] ? wd[0] : port_r;
          default: ;
        endcase
      end
      // single software start returns the type field once complete
      if (done && trg_type == `ADSC_TRG_SINGLE &&
          !(wr_go && wa == `ADSC_OFS_CTRL))
        ctrl_r[2:0] <= `ADSC_TRG_PIN;
    end
  end
  // write channel holding and response
  always @(posedge clk) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      s_bvalid  <= 1'b0;
      s_bresp   <= 2'b00;
    end else begin
      if (aw_fire)
        awaddr_r <= s_awaddr;
      if (w_fire) begin
        wdata_r <= s_wdata;
        wstrb_r <= s_wstrb;
      end
      aw_have_r <= aw_now & ~wr_go;
      w_have_r  <= w_now & ~wr_go;
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp  <= (map_ok(wa) && wa != `ADSC_OFS_STAT &&
                     wa != `ADSC_OFS_RES) ? 2'b00 : 2'b10;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end
  // read channel; status reads leave the ready flag alone
  always @(posedge clk) begin
    if (rst) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= 2'b00;
    end else begin
      if (ar_fire) begin
        s_rvalid <= 1'b1;
        s_rresp  <= map_ok(s_araddr) ? 2'b00 : 2'b10;
        case (s_araddr)
          `ADSC_OFS_CTRL: s_rdata <= ctrl_ext;
          `ADSC_OFS_POS:  s_rdata <= {27'h0, pos_r};
          `ADSC_OFS_NEG:  s_rdata <= {27'h0, neg_r};
          `ADSC_OFS_STAT: s_rdata <= {31'h0, ready_r};
          `ADSC_OFS_RES:  s_rdata <= result_r;
          `ADSC_OFS_GAIN: s_rdata <= {20'h0, gain_r};
          `ADSC_OFS_OFFS: s_rdata <= {20'h0, offs_r};
          `ADSC_OFS_AMP:  s_rdata <= {27'h0, amp_r};
          `ADSC_OFS_PORT: s_rdata <= {31'h0, port_r};
          default:        s_rdata <= 32'h0000_0000;
        endcase
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
  // pin synchroniser, three stages; stage one feeds only stage two
  always @(posedge clk) begin
    if (rst) begin
      pin_s1_r  <= 1'b0;
      pin_s2_r  <= 1'b0;
      pin_s3_r  <= 1'b0;
      pin_lvl_r <= 1'b0;
      t0_d_r    <= 1'b0;
      t1_d_r    <= 1'b0;
      pla_d_r   <= 1'b0;
      pwm_d_r   <= 1'b0;
    end else begin
      pin_s1_r <= convst_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_rise)
        pin_lvl_r <= 1'b1;
      else if (pin_fall)
        pin_lvl_r <= 1'b0;
      t0_d_r  <= timer0_ovf;
      t1_d_r  <= timer1_ovf;
      pla_d_r <= pla_trig;
      pwm_d_r <= pwm_trig;
    end
  end

endmodule

// *** dv/adsc_core_model.sv ***
// behavioural analog core that feeds raw codes to the sequencer
// assumes the code is sampled while busy is high, in the cycle conversion ends
module adsc_core_model (
  // clock
  input  wire logic        clk,
  // sequencer side
  input  wire logic        adc_busy,
  input  wire logic [4:0]  pos_sel,
  // code back to the sequencer
  output logic      [11:0] raw_code
);
  timeunit 1ns;
  timeprecision 1ns;

  initial raw_code = 12'h000;

  // code tied to the channel; when idle it toggles so a stale sample shows
  always @(posedge clk) begin
    raw_code <= adc_busy ? {pos_sel, 7'h2b} : ~raw_code;
  end
endmodule

// *** dv/adsc_monitor.sv ***
// concurrent checks on the ports of the converter sequencing block
// assumes one clock and the synchronous active-high reset
module adsc_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register bus
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic        s_wvalid,
  input wire logic        s_wready,
  input wire logic        s_bvalid,
  input wire logic [7:0]  s_araddr,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  input wire logic [31:0] s_rdata,
  // converter status
  input wire logic        sample_hold,
  input wire logic        adc_busy,
  input wire logic        adc_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] busy_cnt_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // length of the current busy stretch, cleared whenever idle
  always @(posedge clk) begin
    if (rst || !adc_busy) busy_cnt_r <= 12'h000;
    else busy_cnt_r <= busy_cnt_r + 12'h001;
  end

  // acquisition opens the conversion, at least two clocks long
  sequence acq_s;
    sample_hold [*2];
  endsequence

  busy_acq_a: assert property ($rose(adc_busy) |-> acq_s)
    else $error("acquisition missing at conversion start");
  hold_busy_a: assert property (sample_hold |-> adc_busy)
    else $error("sample hold outside busy");
  busy_ready_a: assert property ($fell(adc_busy) |-> adc_irq)
    else $error("busy fell without ready");
  irq_done_a: assert property ($rose(adc_irq) |-> $fell(adc_busy))
    else $error("interrupt rose outside completion");
  busy_min_a: assert property ($fell(adc_busy) |->
    $past(busy_cnt_r) >= 12'h013)
    else $error("conversion shorter than trial clocks");
  busy_max_a: assert property (busy_cnt_r <= 12'ha60)
    else $error("conversion longer than slowest timing");
  res_clear_a: assert property (s_arvalid && s_arready &&
    s_araddr == 8'h10 && !adc_busy |=> !adc_irq)
    else $error("result read left ready set");
  stat_keep_a: assert property (s_arvalid && s_arready &&
    s_araddr == 8'h0c && adc_irq |=> adc_irq)
    else $error("status read cleared ready");
  wr_resp_a: assert property (s_awvalid && s_awready && s_wvalid &&
    s_wready |=> s_bvalid)
    else $error("write response late");
  rd_hold_a: assert property (s_rvalid && !s_rready |=>
    s_rvalid && $stable(s_rdata))
    else $error("read data dropped before ready");
endmodule

bind adsc_top adsc_monitor u_adsc_monitor (.clk, .rst, .s_awvalid,
  .s_awready, .s_wvalid, .s_wready, .s_bvalid, .s_araddr, .s_arvalid,
  .s_arready, .s_rvalid, .s_rready, .s_rdata, .sample_hold, .adc_busy,
  .adc_irq);

// *** dv/tb_top.sv ***
// self-checking bench for the converter sequencing block
// assumes the core model in its own file and the bound monitor
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata;
  logic [4:0]  trg;
  wire         s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  wire  [1:0]  s_bresp, s_rresp;
  wire  [31:0] s_rdata;
  wire  [11:0] raw_code;
  wire  [4:0]  pos_sel, neg_sel, amp_gain;
  wire         sample_hold, adc_power, pos_buf_bypass, neg_buf_bypass;
  wire         adc_busy, port_busy_pin, adc_irq;
  int          n_fail, n_tests;

  adsc_top u_adsc_top (.clk, .rst, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
    .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready, .convst_pin(trg[0]), .timer1_ovf(trg[1]),
    .timer0_ovf(trg[2]), .pla_trig(trg[3]), .pwm_trig(trg[4]), .raw_code,
    .sample_hold, .adc_power, .pos_sel, .neg_sel, .pos_buf_bypass,
    .neg_buf_bypass, .amp_gain, .adc_busy, .port_busy_pin, .adc_irq);
  adsc_core_model u_adsc_core_model (.clk, .adc_busy, .pos_sel, .raw_code);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one write; address and data released each on its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int i;
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (i = 0; i < 20 && s_bvalid !== 1'b1; i++) begin
      @(posedge clk);
      if (s_awready && s_awvalid) s_awvalid <= 1'b0;
      if (s_wready && s_wvalid) s_wvalid <= 1'b0;
    end
    s_bready <= 1'b0;
    chk({s_bvalid, s_bresp}, {1'b1, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] er);
    int i;
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (i = 0; i < 20 && s_rvalid !== 1'b1; i++) begin
      @(posedge clk);
      if (s_arready && s_arvalid) s_arvalid <= 1'b0;
    end
    s_rready <= 1'b0;
    d = s_rdata;
    chk({s_rvalid, s_rresp}, {1'b1, er});
  endtask

  // waits for one conversion, times it, then reads status and result
  task automatic conv(input logic [31:0] res, input int n_exp,
                      input logic pin);
    int k, n;
    logic [31:0] d;
    for (k = 0; k < 100 && adc_busy !== 1'b1; k++) @(posedge clk);
    n = 0;
    while (adc_busy === 1'b1 && n < 4000) begin
      if (n == 2) chk(port_busy_pin, pin);
      @(posedge clk);
      n++;
    end
    chk(n, n_exp);
    chk(adc_irq, 1'b1);
    rd(8'h0c, d, 2'b00);
    rd(8'h0c, d, 2'b00);
    chk(d, 32'h1);
    rd(8'h10, d, 2'b00);
    chk(d, res);
    rd(8'h0c, d, 2'b00);
    chk(d, 32'h0);
  endtask

  task automatic t_reset;
    logic [31:0] d;
    rd(8'h00, d, 2'b00);
    chk(d, 32'h0a00);
    rd(8'h18, d, 2'b00);
    chk(d, 32'h800);
  endtask

  // every hardware trigger type, then one software start
  task automatic t_trig;
    int i;
    logic [31:0] d;
    logic [2:0] t[5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    wr(8'h00, 32'h0a20, 2'b00);
    repeat (50) @(posedge clk);
    wr(8'h04, 32'h2, 2'b00);
    // trigger held through the conversion so the synchronised pin sees it
    for (i = 0; i < 5; i++) begin
      wr(8'h00, {29'h0154, t[i]}, 2'b00);
      trg <= 5'h01 << i;
      conv(32'h012b0000, 54, 1'b0);
      trg <= 5'h00;
    end
    wr(8'h00, 32'h0aa3, 2'b00);
    conv(32'h012b0000, 54, 1'b0);
    rd(8'h00, d, 2'b00);
    chk(d, 32'h0aa0);
    // continuous type restarts by itself until the type changes
    wr(8'h00, 32'h0aa4, 2'b00);
    conv(32'h012b0000, 54, 1'b0);
    chk(adc_busy, 1'b1);
    wr(8'h00, 32'h0aa0, 2'b00);
    for (i = 0; i < 100 && adc_busy === 1'b1; i++) @(posedge clk);
  endtask

  // divider and acquisition codes 0 to 5, slowest paired with fastest
  task automatic t_timing;
    int i;
    for (i = 0; i < 6; i++) begin
      wr(8'h00, (i << 11) | ((5 - i) << 8) | 32'ha3, 2'b00);
      conv(32'h012b0000, (1 << i) * ((2 << (5 - i)) + 19), 1'b0);
    end
  endtask

  task automatic t_temp;
    wr(8'h04, 32'h0d, 2'b00);
    wr(8'h00, 32'h00a3, 2'b00);
    conv(32'h06ab0000, 1120, 1'b0);
    wr(8'h04, 32'h2, 2'b00);
    wr(8'h00, 32'h00a3, 2'b00);
    conv(32'h012b0000, 21, 1'b0);
  endtask

  // differential codes of both signs
  task automatic t_diff;
    wr(8'h04, 32'h3, 2'b00);
    wr(8'h00, 32'h0aab, 2'b00);
    conv(32'hf9ab0000, 54, 1'b0);
    wr(8'h04, 32'h13, 2'b00);
    wr(8'h00, 32'h0aab, 2'b00);
    conv(32'h01ab0000, 54, 1'b0);
  endtask

  // half gain plus offset; amplified pair skips the gain
  task automatic t_cal;
    wr(8'h18, 32'h400, 2'b00);
    wr(8'h1c, 32'h010, 2'b00);
    wr(8'h24, 32'h1, 2'b00);
    wr(8'h04, 32'h2, 2'b00);
    wr(8'h00, 32'h0aa3, 2'b00);
    conv(32'h00a50000, 54, 1'b1);
    wr(8'h04, 32'h0, 2'b00);
    wr(8'h00, 32'h0aa3, 2'b00);
    conv(32'h003b0000, 54, 1'b1);
  endtask

  task automatic t_soft;
    logic [31:0] d;
    wr(8'h00, 32'hc020, 2'b00);
    repeat (2) @(posedge clk);
    chk({adc_power, pos_buf_bypass, neg_buf_bypass}, 3'b111);
    wr(8'h00, 32'h4030, 2'b00);
    wr(8'h04, 32'h16, 2'b00);
    wr(8'h08, 32'h17, 2'b00);
    wr(8'h20, 32'h1f, 2'b00);
    repeat (2) @(posedge clk);
    chk({pos_sel, neg_sel, pos_buf_bypass, neg_buf_bypass},
        {5'h16, 5'h17, 2'b01});
    chk(amp_gain, 5'h1f);
    wr(8'h14, 32'h0, 2'b00);
    rd(8'h00, d, 2'b00);
    chk(d, 32'h0a00);
    rd(8'h18, d, 2'b00);
    chk(d, 32'h800);
    rd(8'h1c, d, 2'b00);
    chk(d, 32'h0);
    rd(8'h20, d, 2'b00);
    chk(d, 32'h0);
  endtask

  task automatic t_bad;
    logic [31:0] d;
    rd(8'h40, d, 2'b10);
    chk(d, 32'h0);
    wr(8'h0c, 32'h1, 2'b10);
    wr(8'h10, 32'h1, 2'b10);
  endtask

  // watchdog well beyond the expected few thousand cycles
  initial begin
    #3000000;
    n_fail++;
    test_done;
  end

  initial begin
    rst = 1'b1;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0;
    trg = 5'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_trig;
    t_timing;
    t_temp;
    t_diff;
    t_cal;
    t_soft;
    t_bad;
    test_done;
  end
endmodule
